//--- fsp_protect.sv
/*
  Flash protection and access control for a 64 kB program array.
  Assumes the array itself, the firmware image and the serial and debug
  engines sit outside; they present requests here and honour the grants.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_protect
  import fsp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Boot strap and nonvolatile image.
  input wire logic bootSelectPin,
  input wire logic [31:0] bootFlagWord,
  input wire fsp_saved_t savedProt,
  input wire logic calibDone,
  // Array access requests from all paths.
  input wire fsp_req_t arrayReq,
  input wire logic [AddrW-1:0] debugRdAddr,
  input wire logic debugRdReq,
  input wire logic cpuFetchFw,
  // Decisions and mode outputs.
  output logic writeGrant,
  output logic writeDenied,
  output logic debugRdGrant,
  output logic fwVisible,
  output logic downloadMode,
  output logic debugPortEn,
  output logic userRun,
  output logic saveStrobe,
  output fsp_saved_t saveData,
  output logic massEraseStrobe
);

  typedef enum logic [1:0] {
    BootCalib,
    BootCapture,
    BootRun
  } fsp_boot_t;

  fsp_boot_t bootQ, bootD;
  logic dlModeQ, dlModeD, dbgEnQ, dbgEnD, userRunQ, userRunD;
  logic [31:0] persistActQ, persistActD;
  logic [31:0] keyQ, keyD;
  logic keyValidQ, keyValidD;
  logic [31:0] volQ, volD, persistQ, persistD;
  logic [31:0] addrQ, addrD, dataQ, dataD;
  logic [15:0] modeQ, modeD;
  logic [7:0] statusQ, statusD;
  logic [31:0] rdataQ, rdataD;
  logic grantQ, grantD, deniedQ, deniedD, dbgRdQ, dbgRdD, fwVisQ, fwVisD;
  logic saveQ, saveD, eraseQ, eraseD;
  fsp_saved_t saveDataQ, saveDataD;
  logic [31:0] activeProt;
  logic [31:0] presentedKey;
  logic cmdWr, passEv, failEv, keyOk, groupProt;
  logic [4:0] groupIdx;

  assign activeProt = volQ | persistActQ;
  assign presentedKey = {addrQ[15:0], dataQ[15:0]};
  assign cmdWr = regWr && (regAddr == RegCommand);
  assign groupIdx = arrayReq.addr[AddrW-1:GroupLsb];
  assign groupProt = activeProt[groupIdx];
  // Firmware group index 31 maps onto the read bit, so the firmware
  // region is refused outright below rather than through the word.

  // A key change is allowed while no key was saved, or the same key is
  // given again, but never once the permanent key is stored.
  assign keyOk = (keyQ != KeyPermanent) &&
    (!keyValidQ || keyQ == KeyErased || presentedKey == keyQ);

  // Boot sequencing and strap capture.
  always_comb begin
    bootD = bootQ;
    dlModeD = dlModeQ;
    dbgEnD = dbgEnQ;
    userRunD = userRunQ;
    persistActD = persistActQ;
    case (bootQ)
      BootCalib: begin
        if (calibDone) begin
          bootD = BootCapture;
        end
      end
      BootCapture: begin
        dlModeD = !bootSelectPin && (bootFlagWord == ErasedWord);
        dbgEnD = bootSelectPin;
        persistActD = savedProt.valid ? savedProt.word : ProtNone;
        bootD = BootRun;
      end
      default: begin
        userRunD = !dlModeQ;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bootQ <= BootCalib;
      dlModeQ <= 1'b0;
      dbgEnQ <= 1'b0;
      userRunQ <= 1'b0;
      persistActQ <= ProtNone;
    end else begin
      bootQ <= bootD;
      dlModeQ <= dlModeD;
      dbgEnQ <= dbgEnD;
      userRunQ <= userRunD;
      persistActQ <= persistActD;
    end
  end

  // Register file, commands and status.
  always_comb begin
    volD = volQ;
    persistD = persistQ;
    addrD = addrQ;
    dataD = dataQ;
    modeD = modeQ;
    keyD = keyQ;
    keyValidD = keyValidQ;
    saveD = 1'b0;
    eraseD = 1'b0;
    saveDataD = saveDataQ;
    passEv = 1'b0;
    failEv = 1'b0;
    if (bootQ == BootCapture) begin
      keyD = savedProt.key;
      keyValidD = savedProt.valid;
      persistD = savedProt.valid ? savedProt.word : ProtNone;
    end
    if (regWr) begin
      if (regAddr == RegVolatile) begin
        volD = regWdata;
      end else if (regAddr == RegPersist) begin
        persistD = regWdata;
      end else if (regAddr == RegAddr) begin
        addrD = regWdata;
      end else if (regAddr == RegData) begin
        dataD = regWdata;
      end else if (regAddr == RegMode) begin
        modeD = regWdata[15:0];
      end
    end
    if (cmdWr && regWdata[7:0] == CmdSaveProt) begin
      if (modeQ[ModeKeyEn] && !modeQ[ModeKeyMode] && keyOk) begin
        keyD = presentedKey;
        keyValidD = 1'b1;
        saveD = 1'b1;
        saveDataD = '{word: persistQ, key: presentedKey, valid: 1'b1};
        passEv = 1'b1;
      end else begin
        failEv = 1'b1;
      end
    end else if (cmdWr && regWdata[7:0] == CmdMassErase) begin
      if (modeQ[ModeWrEn]) begin
        keyD = KeyErased;
        keyValidD = 1'b0;
        eraseD = 1'b1;
        persistD = ProtNone;
        saveDataD = '{word: ProtNone, key: KeyErased, valid: 1'b0};
        passEv = 1'b1;
      end else begin
        failEv = 1'b1;
      end
    end else if (cmdWr) begin
      passEv = 1'b1;
    end
    statusD = statusQ;
    if (regRd && regAddr == RegStatus) begin
      statusD[StPass] = 1'b0;
      statusD[StFail] = 1'b0;
    end
    if (passEv) begin
      statusD[StPass] = 1'b1;
    end
    if (failEv) begin
      statusD[StFail] = 1'b1;
    end
    rdataD = 32'h00000000;
    if (regRd) begin
      if (regAddr == RegStatus) begin
        rdataD = {24'h000000, statusQ};
      end else if (regAddr == RegMode) begin
        rdataD = {16'h0000, modeQ};
      end else if (regAddr == RegData) begin
        rdataD = dataQ;
      end else if (regAddr == RegAddr) begin
        rdataD = addrQ;
      end else if (regAddr == RegPersist) begin
        rdataD = persistQ;
      end else if (regAddr == RegVolatile) begin
        rdataD = volQ;
      end else if (regAddr == RegActive) begin
        rdataD = activeProt;
      end else if (regAddr == RegBoot) begin
        rdataD = {29'h00000000, userRunQ, dbgEnQ, dlModeQ};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      volQ <= ProtNone;
      persistQ <= ProtNone;
      addrQ <= 32'h00000000;
      dataQ <= 32'h00000000;
      modeQ <= ModeReset;
      keyQ <= KeyErased;
      keyValidQ <= 1'b0;
      saveQ <= 1'b0;
      eraseQ <= 1'b0;
      saveDataQ <= '0;
      statusQ <= StatusReset;
      rdataQ <= 32'h00000000;
    end else begin
      volQ <= volD;
      persistQ <= persistD;
      addrQ <= addrD;
      dataQ <= dataD;
      modeQ <= modeD;
      keyQ <= keyD;
      keyValidQ <= keyValidD;
      saveQ <= saveD;
      eraseQ <= eraseD;
      saveDataQ <= saveDataD;
      statusQ <= statusD;
      rdataQ <= rdataD;
    end
  end

  // Access decisions for the array.
  always_comb begin
    grantD = 1'b0;
    deniedD = 1'b0;
    if (arrayReq.valid) begin
      if (arrayReq.addr >= FwBase) begin
        deniedD = 1'b1;
      end else if (groupProt) begin
        deniedD = 1'b1;
      end else if (arrayReq.src == SrcDownload && !dlModeQ) begin
        deniedD = 1'b1;
      end else if (arrayReq.src == SrcDebug && !dbgEnQ) begin
        deniedD = 1'b1;
      end else begin
        grantD = 1'b1;
      end
    end
    dbgRdD = debugRdReq && dbgEnQ && !activeProt[ReadProtBit] &&
      (debugRdAddr < FwBase);
    fwVisD = cpuFetchFw && !userRunQ;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      grantQ <= 1'b0;
      deniedQ <= 1'b0;
      dbgRdQ <= 1'b0;
      fwVisQ <= 1'b0;
    end else begin
      grantQ <= grantD;
      deniedQ <= deniedD;
      dbgRdQ <= dbgRdD;
      fwVisQ <= fwVisD;
    end
  end

  assign regRdata = rdataQ;
  assign writeGrant = grantQ;
  assign writeDenied = deniedQ;
  assign debugRdGrant = dbgRdQ;
  assign fwVisible = fwVisQ;
  assign downloadMode = dlModeQ;
  assign debugPortEn = dbgEnQ;
  assign userRun = userRunQ;
  assign saveStrobe = saveQ;
  assign saveData = saveDataQ;
  assign massEraseStrobe = eraseQ;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  ReadBlock_a: assert property (
    activeProt[ReadProtBit] |=> !debugRdGrant)
    else $error("debug read granted while read protected");
  GroupWrite_a: assert property (
    arrayReq.valid && groupProt |=> writeDenied && !writeGrant)
    else $error("write granted to protected group");
  FwHidden_a: assert property (
    arrayReq.valid && arrayReq.addr >= FwBase |=> !writeGrant)
    else $error("firmware region reached");
  BootDecide_a: assert property (
    bootQ == BootCapture |=> downloadMode ==
      (!$past(bootSelectPin) && $past(bootFlagWord) == ErasedWord))
    else $error("download mode decision wrong");
  DebugPins_a: assert property (
    debugPortEn |-> bootQ == BootRun)
    else $error("debug port enabled before capture");
  StatusClear_a: assert property (
    regRd && regAddr == RegStatus && !cmdWr |=> !statusQ[StPass])
    else $error("pass flag survived a status read");
  KeyRefuse_a: assert property (
    keyQ == KeyPermanent && cmdWr |=> !saveStrobe)
    else $error("permanent key allowed a change");
  EraseKey_a: assert property (
    massEraseStrobe |-> keyQ == KeyErased && saveData.key == KeyErased)
    else $error("mass erase left key set");
  UnionProt_a: assert property (
    regRd && regAddr == RegActive |=> regRdata == $past(activeProt))
    else $error("active protection not the union");

  SaveSeen_c: cover property (saveStrobe);
  DenySeen_c: cover property (writeDenied);
  DlMode_c: cover property (downloadMode);
  DbgRead_c: cover property (debugRdGrant);

endmodule : fsp_protect
`default_nettype wire

//--- fsp_pkg.sv
/*
  Package for the flash protection block: register indices, field
  positions, reset values, command codes and the carrier structs.
  Assumes a plain register port with one-cycle read latency.
*/
package fsp_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] RegStatus = 4'h0;
  localparam logic [3:0] RegMode = 4'h1;
  localparam logic [3:0] RegCommand = 4'h2;
  localparam logic [3:0] RegData = 4'h3;
  localparam logic [3:0] RegAddr = 4'h4;
  localparam logic [3:0] RegPersist = 4'h5;
  localparam logic [3:0] RegVolatile = 4'h6;
  localparam logic [3:0] RegActive = 4'h7;
  localparam logic [3:0] RegBoot = 4'h8;

  // Array geometry: 64 kB total, 62 kB user, 2 kB firmware.
  localparam int ArrayBytes = 65536;
  localparam int UserBytes = 63488;
  localparam int GroupBytes = 2048;
  localparam int AddrW = 16;
  localparam logic [15:0] FwBase = 16'hF800;
  localparam int GroupLsb = 11;

  // Boot flag word address and its erased value.
  localparam logic [19:0] BootFlagAddr = 20'h80014;
  localparam logic [31:0] ErasedWord = 32'hFFFFFFFF;

  // Status register fields.
  localparam int StPass = 0;
  localparam int StFail = 1;
  localparam int StBusy = 2;
  localparam logic [7:0] StatusReset = 8'h00;

  // Mode register fields.
  localparam int ModeWrEn = 3;
  localparam int ModeKeyMode = 5;
  localparam int ModeKeyEn = 6;
  localparam logic [15:0] ModeReset = 16'h0000;

  // Commands and key values.
  localparam logic [7:0] CmdSaveProt = 8'h0C;
  localparam logic [7:0] CmdMassErase = 8'h03;
  localparam logic [7:0] CmdWrite = 8'h02;
  localparam logic [7:0] CmdErasePage = 8'h05;
  localparam logic [31:0] KeyErased = 32'hFFFFFFFF;
  localparam logic [31:0] KeyPermanent = 32'hDEADDEAD;
  localparam int ReadProtBit = 31;
  localparam logic [31:0] ProtNone = 32'h00000000;

  // Source of a write request to the array.
  typedef enum logic [1:0] {
    SrcCpu,
    SrcDownload,
    SrcDebug
  } fsp_src_t;

  typedef struct packed {
    logic valid;
    fsp_src_t src;
    logic erase;
    logic [AddrW-1:0] addr;
  } fsp_req_t;

  typedef struct packed {
    logic [31:0] word;
    logic [31:0] key;
    logic valid;
  } fsp_saved_t;

endpackage : fsp_pkg

//--- fsp_host_model.sv
/*
  Download host and debug pod model: array writes and debug reads.
  Assumes the bench calls its tasks and the block samples on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model
  import fsp_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Requests toward the block.
  output fsp_req_t arrayReq,
  output logic [AddrW-1:0] debugRdAddr,
  output logic debugRdReq
);
  initial begin
    arrayReq = '0;
    debugRdAddr = '0;
    debugRdReq = 1'b0;
  end

  // Released address lines show the inverse, never a stale value.
  task automatic put(input fsp_src_t s, input logic [15:0] a);
    @(posedge clk_sys);
    arrayReq <= '{1'b1, s, 1'b0, a};
    @(posedge clk_sys);
    arrayReq <= '{1'b0, s, 1'b0, ~a};
  endtask : put

  task automatic peek(input logic [15:0] a);
    @(posedge clk_sys);
    debugRdAddr <= a;
    debugRdReq <= 1'b1;
    @(posedge clk_sys);
    debugRdReq <= 1'b0;
    debugRdAddr <= ~a;
  endtask : peek
endmodule : fsp_host_model
`default_nettype wire

//--- test_fsp_protect.sv
/*
  Bench for the flash protection block: boot, protection words, key
  save and mass erase. Assumes fsp_pkg and the host model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_fsp_protect
  import fsp_pkg::*;
;
  logic clk_sys, rst, regWr, regRd, bootSelectPin, calibDone, cpuFetchFw;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, bootFlagWord, rdv;
  fsp_saved_t savedProt, saveData;
  fsp_req_t arrayReq;
  logic [AddrW-1:0] debugRdAddr;
  logic debugRdReq, writeGrant, writeDenied, debugRdGrant, fwVisible;
  logic downloadMode, debugPortEn, userRun, saveStrobe, massEraseStrobe;
  logic sv, me;
  fsp_saved_t sd;
  int bad_count, n_tests;

  fsp_protect u_fsp_protect (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bootSelectPin(bootSelectPin),
    .bootFlagWord(bootFlagWord), .savedProt(savedProt),
    .calibDone(calibDone), .arrayReq(arrayReq),
    .debugRdAddr(debugRdAddr), .debugRdReq(debugRdReq),
    .cpuFetchFw(cpuFetchFw), .writeGrant(writeGrant),
    .writeDenied(writeDenied), .debugRdGrant(debugRdGrant),
    .fwVisible(fwVisible), .downloadMode(downloadMode),
    .debugPortEn(debugPortEn), .userRun(userRun),
    .saveStrobe(saveStrobe), .saveData(saveData),
    .massEraseStrobe(massEraseStrobe));

  fsp_host_model u_fsp_host_model (.clk_sys(clk_sys),
    .arrayReq(arrayReq), .debugRdAddr(debugRdAddr),
    .debugRdReq(debugRdReq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask : rd

  // Resets, runs the calibration phase and checks the boot decision.
  task automatic boot(input logic p, input logic [31:0] f,
                      input fsp_saved_t s);
    int i;
    logic dl;
    dl = ~p & (f == ErasedWord);
    @(posedge clk_sys);
    rst <= 1'b1;
    calibDone <= 1'b0;
    bootSelectPin <= p;
    bootFlagWord <= f;
    savedProt <= s;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk(32'(userRun), 32'h0);
    @(posedge clk_sys);
    cpuFetchFw <= 1'b1;
    @(posedge clk_sys);
    cpuFetchFw <= 1'b0;
    calibDone <= 1'b1;
    #1 chk(32'(fwVisible), 32'h1);
    i = 0;
    // Download mode keeps user code halted, so either level ends the wait.
    while (userRun !== 1'b1 && downloadMode !== 1'b1 && i < 10) begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (i == 10) begin
      bad_count++;
      finish_test();
    end
    chk(32'({downloadMode, debugPortEn}), 32'({dl, p}));
    rd(RegBoot);
    chk(rdv, {29'h0, ~dl, p, dl});
  endtask : boot

  task automatic tryw(input fsp_src_t s, input logic [15:0] a,
                      input logic ok);
    u_fsp_host_model.put(s, a);
    #1 chk(32'({writeGrant, writeDenied}), ok ? 32'h2 : 32'h1);
  endtask : tryw

  task automatic peek(input logic [15:0] a, input logic ok);
    u_fsp_host_model.peek(a);
    #1 chk(32'(debugRdGrant), 32'(ok));
  endtask : peek

  task automatic watch;
    int i;
    sv = 1'b0;
    me = 1'b0;
    for (i = 0; i < 4; i++) begin
      #1 me = me | (massEraseStrobe === 1'b1);
      if (saveStrobe === 1'b1) begin
        sv = 1'b1;
        sd = saveData;
      end
      @(posedge clk_sys);
    end
  endtask : watch

  // Key save sequence as software runs it, then the status flags.
  task automatic save(input logic [31:0] w, input logic [31:0] k,
                      input logic ok);
    wr(RegPersist, w);
    wr(RegMode, 32'h0000_0040);
    wr(RegAddr, {16'h0000, k[31:16]});
    wr(RegData, {16'h0000, k[15:0]});
    wr(RegCommand, {24'h0, CmdSaveProt});
    watch();
    chk(32'(sv), 32'(ok));
    if (ok) chk(sd.key, k);
    if (ok) chk(sd.word, w);
    rd(RegStatus);
    chk(rdv & 32'h3, ok ? 32'h1 : 32'h2);
    rd(RegStatus);
    chk(rdv & 32'h3, 32'h0);
  endtask : save

  initial begin
    bad_count = 0;
    n_tests = 0;
    rst = 1'b1;
    {regWr, regRd, calibDone, cpuFetchFw, bootSelectPin} = 5'h0;
    regAddr = 4'h0;
    regWdata = 32'h0;
    bootFlagWord = 32'h0;
    savedProt = '0;
    boot(1'b1, 32'h0, '0);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF);
    chk(rdv, 32'h0);
    wr(RegCommand, {24'h0, CmdWrite});
    rd(RegStatus);
    chk(rdv & 32'h3, 32'h1);
    wr(RegVolatile, 32'hC000_0002);
    rd(RegActive);
    chk(rdv, 32'hC000_0002);
    tryw(SrcCpu, 16'h0800, 1'b0);
    tryw(SrcCpu, 16'h1000, 1'b1);
    tryw(SrcCpu, 16'hF7FF, 1'b0);
    tryw(SrcDebug, 16'h0FFF, 1'b0);
    tryw(SrcDebug, 16'h07FF, 1'b1);
    tryw(SrcCpu, FwBase, 1'b0);
    tryw(SrcDownload, 16'h0000, 1'b0);
    peek(16'h0100, 1'b0);
    wr(RegVolatile, 32'h0);
    peek(16'h0100, 1'b1);
    peek(FwBase, 1'b0);
    @(posedge clk_sys);
    cpuFetchFw <= 1'b1;
    @(posedge clk_sys);
    cpuFetchFw <= 1'b0;
    #1 chk(32'(fwVisible), 32'h0);
    save(32'h0000_0010, 32'h1234_5678, 1'b1);
    rd(RegActive);
    chk(rdv, 32'h0);
    boot(1'b0, 32'hFFFF_FFFF, '{32'h10, 32'h1234_5678, 1'b1});
    rd(RegActive);
    chk(rdv, 32'h0000_0010);
    tryw(SrcDownload, 16'h2000, 1'b0);
    tryw(SrcDownload, 16'h2800, 1'b1);
    peek(16'h0100, 1'b0);
    save(32'h0, 32'h1111_1111, 1'b0);
    save(32'h0, 32'h1234_5678, 1'b1);
    wr(RegMode, 32'h0000_0008);
    wr(RegCommand, {24'h0, CmdMassErase});
    watch();
    chk(32'(me), 32'h1);
    rd(RegPersist);
    chk(rdv, 32'h0);
    save(32'h4, KeyPermanent, 1'b1);
    boot(1'b0, 32'h0, '{32'h4, KeyPermanent, 1'b1});
    save(32'h0, KeyPermanent, 1'b0);
    finish_test();
  end
endmodule : test_fsp_protect
`default_nettype wire
